// >>> rtl/lcd_reset_mode_sequencer.sv
// Purpose: Reset and operating mode control of a passive matrix display driver.
// Assumes: Host cycles arrive as writes to the host cycle register.
// Notes: Mode changes from the display command wait for an internal clock tick.
`timescale 1ns/1ns
`default_nettype none

module lcd_reset_mode_sequencer #(
  parameter int unsigned POR_WAIT_CYCLES = lcd_seq_pkg::POR_WAIT_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Avalon-MM register slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Device pins and analog status
  input wire logic reset_pin_n,
  input wire logic lcd_drive_voltage_external,
  input wire logic lcd_drive_voltage_ready,
  input wire logic bias_voltage_ready,
  // Mode and status
  output logic [1:0] operating_mode_code,
  output logic reset_in_progress_flag,
  output logic busy_flag,
  output logic [2:0] display_control_field,
  // Power and driver controls
  output logic int_clock_run,
  output logic charge_pump_on,
  output logic drivers_on,
  output logic drain_lcd_drive_voltage_on,
  output logic drain_bias_on,
  // Decoded traffic to other blocks
  output logic cmd_strobe,
  output logic [7:0] cmd_byte,
  output logic ram_write_strobe,
  output logic [7:0] ram_write_data
);

  typedef struct packed {
    lcd_seq_pkg::phase_t phase;
    logic [lcd_seq_pkg::POR_CNT_W-1:0] por_cnt;
    logic [lcd_seq_pkg::SEQ_CNT_W-1:0] seq_cnt;
    logic [1:0] mode;
    logic [2:0] dc;
    logic mode_pending;
    logic [7:0] snap;
    logic ack;
    logic [31:0] rdata;
    logic cmd_stb;
    logic [7:0] cmd_val;
    logic ram_stb;
    logic [7:0] ram_val;
    logic drv_on;
  } state_t;

  localparam logic [lcd_seq_pkg::POR_CNT_W-1:0] POR_LAST =
    lcd_seq_pkg::POR_CNT_W'(POR_WAIT_CYCLES - 1);
  localparam logic [lcd_seq_pkg::SEQ_CNT_W-1:0] SEQ_LAST =
    lcd_seq_pkg::SEQ_CNT_W'(lcd_seq_pkg::RESET_SEQ_CYCLES - 1);

  state_t state_reg;
  state_t state_next;
  logic int_tick;

  // Internal clock edges; also paces mode updates
  tick_divider #(
    .DIV(lcd_seq_pkg::INT_CLK_DIV)
  ) u_int_clk (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .tick(int_tick)
  );

  // Bus decode helpers
  logic access;
  logic take;
  logic wr_host;
  logic rd_status;
  logic rd_snap;
  logic [7:0] hc_byte;
  logic hc_cd;
  logic hc_dir;
  logic in_reset;
  logic is_disp_en;
  logic [1:0] target_mode;
  logic [7:0] status_byte;
  logic [31:0] status_word;
  logic volts_ready;
  logic is_command;
  logic is_write;
  logic cyc_ram_write;
  logic cyc_read_status;
  logic cyc_sys_reset;
  logic cyc_disp_en;
  logic cyc_other_cmd;
  logic mode_normal;
  logic mode_step;
  logic por_done;
  logic seq_done;
  logic pin_reset;
  logic [31:0] rdata_sel;

  assign access = avs_read | avs_write;
  // Request completes on the cycle after it is first seen
  assign take = access & state_reg.ack;
  assign wr_host = take & avs_write & (avs_address == lcd_seq_pkg::HOST_CYCLE_OFFSET);
  assign rd_status = avs_read & (avs_address == lcd_seq_pkg::STATUS_OFFSET);
  assign rd_snap = avs_read & (avs_address == lcd_seq_pkg::STATUS_SNAP_OFFSET);

  assign hc_byte = avs_writedata[lcd_seq_pkg::HC_BYTE_LSB +: 8];
  assign hc_cd = avs_writedata[lcd_seq_pkg::HC_CD_BIT];
  assign hc_dir = avs_writedata[lcd_seq_pkg::HC_DIR_BIT];

  assign in_reset = (state_reg.phase != lcd_seq_pkg::PHASE_RUN);
  assign is_disp_en = (hc_byte[7:3] == lcd_seq_pkg::CMD_DISPLAY_ENABLE_TOP);

  // Mode follows driver enable of the display control field
  assign target_mode = state_reg.dc[lcd_seq_pkg::DC_DRIVER_EN_BIT] ?
    lcd_seq_pkg::MODE_NORMAL : lcd_seq_pkg::MODE_SLEEP;

  // Both voltages must be back before drivers leave idle
  assign volts_ready = lcd_drive_voltage_ready & bias_voltage_ready;

  // Host cycle kinds; at most one is set per taken write
  // Decoded only on the answering edge, so a held request acts once
  assign is_command = (hc_cd == lcd_seq_pkg::CYCLE_COMMAND);
  assign is_write = (hc_dir == lcd_seq_pkg::DIR_WRITE);
  assign cyc_ram_write = wr_host & ~is_command & is_write;
  assign cyc_read_status = wr_host & is_command & ~is_write;
  assign cyc_sys_reset = wr_host & is_command & is_write &
    (hc_byte == lcd_seq_pkg::CMD_SYSTEM_RESET);
  assign cyc_disp_en = wr_host & is_command & is_write & is_disp_en;
  assign cyc_other_cmd = wr_host & is_command & is_write & ~is_disp_en &
    (hc_byte != lcd_seq_pkg::CMD_SYSTEM_RESET);

  // Clock, pump and drains all key off one decode
  assign mode_normal = (state_reg.mode == lcd_seq_pkg::MODE_NORMAL);

  // Outside reset, mode moves only on an internal clock edge
  assign mode_step = ~in_reset & state_reg.mode_pending & int_tick;

  // Sequence counters at their last count
  assign por_done = (state_reg.por_cnt == POR_LAST);
  assign seq_done = (state_reg.seq_cnt == SEQ_LAST);

  // Pin level is already synchronous to the system clock
  assign pin_reset = ~reset_pin_n;

  always_comb begin
    status_byte = 8'h00;
    status_byte[lcd_seq_pkg::ST_MODE_LSB +: 2] = state_reg.mode;
    status_byte[lcd_seq_pkg::ST_RIP_BIT] = in_reset;
    status_byte[lcd_seq_pkg::ST_BUSY_BIT] = in_reset;
    status_byte[lcd_seq_pkg::ST_DRV_BIT] = state_reg.drv_on;
    status_byte[lcd_seq_pkg::ST_DC_LSB +: 3] = state_reg.dc;
    status_word = {24'h000000, status_byte};
  end

  // Read data picked in the first cycle, shown in the second
  always_comb begin
    // Unmapped offsets read as zero
    rdata_sel = lcd_seq_pkg::UNMAPPED_READ_VALUE;
    if (rd_status) begin
      // Status read is always served, reset or not
      rdata_sel = status_word;
    end else if (rd_snap) begin
      rdata_sel = {24'h000000, state_reg.snap};
    end
  end

  always_comb begin
    state_next = state_reg;
    state_next.cmd_stb = 1'b0;
    state_next.ram_stb = 1'b0;

    // Bus handshake: one wait cycle, then answer
    state_next.ack = access & ~state_reg.ack;
    if (access & ~state_reg.ack) begin
      state_next.rdata = rdata_sel;
    end

    // Reset sequence
    case (state_reg.phase)
      lcd_seq_pkg::PHASE_POR_WAIT: begin
        if (por_done) begin
          state_next.phase = lcd_seq_pkg::PHASE_RESET_SEQ;
          state_next.seq_cnt = '0;
        end else begin
          state_next.por_cnt = state_reg.por_cnt + 1'b1;
        end
      end
      lcd_seq_pkg::PHASE_RESET_SEQ: begin
        if (seq_done) begin
          // Flags drop and decoding resumes
          state_next.phase = lcd_seq_pkg::PHASE_RUN;
        end else begin
          state_next.seq_cnt = state_reg.seq_cnt + 1'b1;
        end
      end
      lcd_seq_pkg::PHASE_RUN: begin
        // Host cycles; any order, no spacing needed
        if (cyc_ram_write) begin
          // RAM keeps and accepts data in Sleep too
          state_next.ram_stb = 1'b1;
          state_next.ram_val = hc_byte;
        end
        // Data read cycles are not decoded and fall through
        if (cyc_sys_reset) begin
          state_next.phase = lcd_seq_pkg::PHASE_RESET_SEQ;
          state_next.seq_cnt = '0;
        end
        if (cyc_disp_en) begin
          if (hc_byte[2:0] != state_reg.dc) begin
            state_next.mode_pending = 1'b1;
          end
          state_next.dc = hc_byte[2:0];
        end
        if (cyc_other_cmd) begin
          state_next.cmd_stb = 1'b1;
          state_next.cmd_val = hc_byte;
        end
      end
      default: begin
        state_next.phase = lcd_seq_pkg::PHASE_RESET_SEQ;
        state_next.seq_cnt = '0;
      end
    endcase

    // Command writes seen while resetting are dropped, not queued
    // Read-status cycles execute in every phase, reset too
    if (cyc_read_status) begin
      state_next.snap = status_byte;
    end

    // Deferred mode update on an internal clock edge
    if (mode_step) begin
      state_next.mode = target_mode;
      state_next.mode_pending = 1'b0;
    end

    // Driver release waits for ready voltages in Normal
    state_next.drv_on = (state_next.mode == lcd_seq_pkg::MODE_NORMAL) &
      volts_ready & ~state_next.mode_pending;

    // Pin reset wins over everything else
    if (pin_reset) begin
      state_next.phase = lcd_seq_pkg::PHASE_RESET_SEQ;
      state_next.seq_cnt = '0;
      state_next.cmd_stb = 1'b0;
      state_next.ram_stb = 1'b0;
    end

    // Any reset restores the display control default, clears a pending mode change and enters Reset mode
    if (state_next.phase == lcd_seq_pkg::PHASE_RESET_SEQ &&
        state_reg.phase != lcd_seq_pkg::PHASE_RESET_SEQ) begin
      state_next.mode = lcd_seq_pkg::MODE_RESET;
      state_next.dc = lcd_seq_pkg::DC_RESET_VALUE;
      state_next.mode_pending = 1'b0;
      state_next.drv_on = 1'b0;
    end
    if (state_next.phase != lcd_seq_pkg::PHASE_RUN) begin
      state_next.mode = lcd_seq_pkg::MODE_RESET;
      state_next.drv_on = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_reg.phase <= lcd_seq_pkg::PHASE_POR_WAIT;
      state_reg.por_cnt <= '0;
      state_reg.seq_cnt <= '0;
      state_reg.mode <= lcd_seq_pkg::MODE_RESET;
      state_reg.dc <= lcd_seq_pkg::DC_RESET_VALUE;
      state_reg.mode_pending <= 1'b0;
      state_reg.snap <= lcd_seq_pkg::SNAP_RESET_VALUE;
      state_reg.ack <= 1'b0;
      state_reg.rdata <= 32'h00000000;
      state_reg.cmd_stb <= 1'b0;
      state_reg.cmd_val <= 8'h00;
      state_reg.ram_stb <= 1'b0;
      state_reg.ram_val <= 8'h00;
      state_reg.drv_on <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  // Register port
  assign avs_waitrequest = access & ~state_reg.ack;
  assign avs_readdata = state_reg.rdata;

  // Status outputs
  assign operating_mode_code = state_reg.mode;
  assign reset_in_progress_flag = in_reset;
  assign busy_flag = in_reset;
  // Sleep leaves the field untouched
  assign display_control_field = state_reg.dc;

  // Power controls follow the mode table
  assign int_clock_run = mode_normal;
  assign charge_pump_on = mode_normal;
  assign drivers_on = state_reg.drv_on;
  // Never sink an externally supplied drive voltage
  assign drain_lcd_drive_voltage_on = ~mode_normal & ~lcd_drive_voltage_external;
  assign drain_bias_on = ~mode_normal;

  // Decoded traffic
  assign cmd_strobe = state_reg.cmd_stb;
  assign cmd_byte = state_reg.cmd_val;
  assign ram_write_strobe = state_reg.ram_stb;
  assign ram_write_data = state_reg.ram_val;

endmodule : lcd_reset_mode_sequencer

`default_nettype wire

// >>> rtl/tick_divider.sv
// Purpose: Divides the system clock into a one-cycle enable pulse.
// Assumes: DIV of at least 2.
// Notes: Free running; stands in for the internal oscillator edge.
`timescale 1ns/1ns
`default_nettype none

module tick_divider #(
  parameter int unsigned DIV = 8
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Enable pulse
  output logic tick
);

  localparam int CW = $clog2(DIV);
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic [CW-1:0] count_reg;
  logic [CW-1:0] count_next;

  always_comb begin
    count_next = (count_reg == LAST) ? '0 : count_reg + 1'b1;
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end

  assign tick = (count_reg == LAST);

endmodule : tick_divider

`default_nettype wire

// >>> shared/lcd_seq_pkg.sv
// Purpose: Shared constants for the display reset and mode sequencer.
// Assumes: 25 MHz system clock; 32-bit Avalon-MM register port.
// Notes: Register offsets are byte addresses of aligned words.
package lcd_seq_pkg;

  // Clock and timing
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned POR_WAIT_US = 10000;
  localparam int unsigned POR_WAIT_CYCLES = (POR_WAIT_US * (CLK_HZ / 1000000));
  localparam int unsigned RESET_SEQ_CYCLES = 16;
  localparam int unsigned INT_CLK_DIV = 8;
  localparam int POR_CNT_W = 18;
  localparam int SEQ_CNT_W = 5;

  // Register map
  localparam logic [3:0] HOST_CYCLE_OFFSET = 4'h0;
  localparam logic [3:0] STATUS_OFFSET = 4'h4;
  localparam logic [3:0] STATUS_SNAP_OFFSET = 4'h8;
  localparam logic [31:0] UNMAPPED_READ_VALUE = 32'h00000000;

  // Host cycle register fields
  localparam int HC_BYTE_LSB = 0;
  localparam int HC_CD_BIT = 8;
  localparam int HC_DIR_BIT = 9;

  // Status register fields
  localparam int ST_MODE_LSB = 0;
  localparam int ST_RIP_BIT = 2;
  localparam int ST_BUSY_BIT = 3;
  localparam int ST_DRV_BIT = 4;
  localparam int ST_DC_LSB = 5;

  // Cycle type encodings
  localparam logic CYCLE_COMMAND = 1'b0;
  localparam logic CYCLE_DATA = 1'b1;
  localparam logic DIR_WRITE = 1'b0;
  localparam logic DIR_READ = 1'b1;

  // Operating mode codes
  localparam logic [1:0] MODE_RESET = 2'h0;
  localparam logic [1:0] MODE_SLEEP = 2'h2;
  localparam logic [1:0] MODE_NORMAL = 2'h3;

  // Command decoding
  localparam logic [7:0] CMD_SYSTEM_RESET = 8'he2;
  localparam logic [4:0] CMD_DISPLAY_ENABLE_TOP = 5'h15;
  localparam int DC_DRIVER_EN_BIT = 0;

  // Reset values
  localparam logic [2:0] DC_RESET_VALUE = 3'h0;
  localparam logic [7:0] SNAP_RESET_VALUE = 8'h00;

  // Sequencer phases
  typedef enum logic [1:0] {
    PHASE_POR_WAIT,
    PHASE_RESET_SEQ,
    PHASE_RUN
  } phase_t;

endpackage : lcd_seq_pkg

// >>> verification/host_bus_model.sv
// Purpose: Host controller model issuing Avalon register cycles
// Assumes: Waits for waitrequest low, bounded at 50 edges
// Notes: Released write data is inverted so stale values never look valid
`timescale 1ns/1ns
`default_nettype none
module host_bus_model (
  // Clock
  input wire logic clk_sys,
  // Avalon master side
  output logic [3:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest
);
  logic hang = 1'b0;
  logic [31:0] dummy;
  initial begin
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
  end
  task xfer(input logic rw, input logic [3:0] a, input logic [31:0] w, output logic [31:0] r);
    int i;
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= w;
    avs_read <= rw;
    avs_write <= !rw;
    @(posedge clk_sys);
    i = 1;
    while (avs_waitrequest !== 1'b0 && i < 50) begin
      @(posedge clk_sys);
      i++;
    end
    if (avs_waitrequest !== 1'b0) hang = 1'b1;
    r = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    avs_writedata <= ~w;
  endtask : xfer
  task wr(input logic [3:0] a, input logic [31:0] w);
    xfer(1'b0, a, w, dummy);
  endtask : wr
  task rd(input logic [3:0] a, output logic [31:0] r);
    xfer(1'b1, a, 32'h0, r);
  endtask : rd
endmodule : host_bus_model
`default_nettype wire

// >>> verification/seq_chk_properties.sv
// Purpose: Port checks for the reset and mode sequencer
// Assumes: Bound to the sequencer top, one clock domain
// Notes: Mode changes are allowed one internal tick of slack
`timescale 1ns/1ns
`default_nettype none
module seq_chk (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Bus and pins
  input wire logic avs_read,
  input wire logic avs_waitrequest,
  input wire logic reset_pin_n,
  input wire logic lcd_drive_voltage_external,
  input wire logic lcd_drive_voltage_ready,
  input wire logic bias_voltage_ready,
  // Status and power
  input wire logic [1:0] operating_mode_code,
  input wire logic reset_in_progress_flag,
  input wire logic busy_flag,
  input wire logic [2:0] display_control_field,
  input wire logic int_clock_run,
  input wire logic charge_pump_on,
  input wire logic drivers_on,
  input wire logic drain_lcd_drive_voltage_on,
  input wire logic drain_bias_on
);
  wire logic norm = operating_mode_code == 2'h3;
  wire logic rdy = lcd_drive_voltage_ready && bias_voltage_ready;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  property p_flags; reset_in_progress_flag == busy_flag; endproperty
  a_flags: assert property (p_flags) else $error("flags differ");
  property p_pin; !reset_pin_n |=> reset_in_progress_flag; endproperty
  a_pin: assert property (p_pin) else $error("pin reset missed");
  property p_rmode; reset_in_progress_flag [*3] |-> operating_mode_code == 2'h0; endproperty
  a_rmode: assert property (p_rmode) else $error("mode not reset");
  property p_pwr;
    int_clock_run == norm && charge_pump_on == norm && drain_bias_on == !norm;
  endproperty
  a_pwr: assert property (p_pwr) else $error("power controls wrong");
  property p_lcd_drive_voltage; drain_lcd_drive_voltage_on == (!norm && !lcd_drive_voltage_external); endproperty
  a_lcd_drive_voltage: assert property (p_lcd_drive_voltage) else $error("drive drain wrong");
  property p_drv; drivers_on |-> norm && $past(rdy); endproperty
  a_drv: assert property (p_drv) else $error("drivers early");
  property p_off; !norm |-> !drivers_on; endproperty
  a_off: assert property (p_off) else $error("drivers left on");
  property p_mode;
    $changed(display_control_field) && !reset_in_progress_flag
      |-> ##[0:8] operating_mode_code == {1'b1, display_control_field[0]};
  endproperty
  a_mode: assert property (p_mode) else $error("mode not updated");
  property p_wait; $rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest; endproperty
  a_wait: assert property (p_wait) else $error("bus answer late");
  c_norm: cover property (norm && drivers_on);
  c_sleep: cover property (operating_mode_code == 2'h2);
  c_done: cover property ($fell(reset_in_progress_flag));
endmodule : seq_chk
bind lcd_reset_mode_sequencer seq_chk seq_chk_inst (.clk_sys, .nrst, .avs_read,
  .avs_waitrequest, .reset_pin_n, .lcd_drive_voltage_external, .lcd_drive_voltage_ready,
  .bias_voltage_ready, .operating_mode_code, .reset_in_progress_flag, .busy_flag,
  .display_control_field, .int_clock_run, .charge_pump_on, .drivers_on,
  .drain_lcd_drive_voltage_on, .drain_bias_on);
`default_nettype wire

// >>> verification/tb.sv
// Purpose: Self-checking bench for the reset and mode sequencer
// Assumes: Power-on wait shortened to 20 cycles
// Notes: Mode waits of 12 cycles cover one internal tick
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic reset_pin_n = 1'b1;
  logic lcd_drive_voltage_external = 1'b0;
  logic lcd_drive_voltage_ready = 1'b1;
  logic bias_voltage_ready = 1'b0;
  logic [3:0] avs_address;
  logic avs_read, avs_write, avs_waitrequest;
  logic [31:0] avs_writedata, avs_readdata, d;
  logic [1:0] operating_mode_code;
  logic [2:0] display_control_field;
  logic reset_in_progress_flag, busy_flag, int_clock_run, charge_pump_on, drivers_on;
  logic drain_lcd_drive_voltage_on, drain_bias_on, cmd_strobe, ram_write_strobe;
  logic [7:0] cmd_byte, ram_write_data;
  int failures = 0;
  int compares = 0;
  int k;
  always #20 clk_sys = ~clk_sys;
  lcd_reset_mode_sequencer #(.POR_WAIT_CYCLES(20)) lcd_reset_mode_sequencer_inst (.clk_sys,
    .nrst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
    .avs_waitrequest, .reset_pin_n, .lcd_drive_voltage_external, .lcd_drive_voltage_ready,
    .bias_voltage_ready, .operating_mode_code, .reset_in_progress_flag, .busy_flag,
    .display_control_field, .int_clock_run, .charge_pump_on, .drivers_on, .drain_lcd_drive_voltage_on,
    .drain_bias_on, .cmd_strobe, .cmd_byte, .ram_write_strobe, .ram_write_data);
  host_bus_model host_bus_model_inst (.clk_sys, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest);
  // A bus that never answers ends the run as a failure
  always @(posedge clk_sys) begin
    if (host_bus_model_inst.hang) begin
      $display("[FAIL] t=%0t got %h exp %h", $time, 1'b1, 1'b0);
      final_report;
    end
  end
  task final_report;
    if (host_bus_model_inst.hang) failures++;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  task chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task hc(input logic [9:0] w);
    host_bus_model_inst.wr(4'h0, {22'h0, w});
    @(negedge clk_sys);
  endtask : hc
  task st(input logic [7:0] e);
    host_bus_model_inst.rd(4'h4, d);
    chk(d, {24'h0, e});
  endtask : st
  task pw(input logic [4:0] e);
    @(negedge clk_sys);
    chk({27'h0, int_clock_run, charge_pump_on, drivers_on, drain_lcd_drive_voltage_on, drain_bias_on},
      {27'h0, e});
  endtask : pw
  // Polls until the reset flag drops; hang is a failure
  task settle;
    for (k = 0; k < 100; k++) begin
      host_bus_model_inst.rd(4'h4, d);
      if (d[2] === 1'b0) break;
    end
    if (k == 100) begin
      failures++;
      $display("[FAIL] t=%0t got %h exp %h", $time, d, 32'h0);
      final_report;
    end
  endtask : settle
  initial begin
    repeat (3) @(posedge clk_sys);
    nrst <= 1'b1;
    st(8'h0c);
    hc(10'h0af);
    settle;
    st(8'h00);
    pw(5'h03);
    $display("test power-on reset done");
    hc(10'h0af);
    repeat (12) @(posedge clk_sys);
    st(8'he3);
    pw(5'h18);
    @(posedge clk_sys) bias_voltage_ready <= 1'b1;
    repeat (3) @(posedge clk_sys);
    st(8'hf3);
    pw(5'h1c);
    $display("test normal done");
    hc(10'h0ae);
    repeat (12) @(posedge clk_sys);
    st(8'hc2);
    pw(5'h03);
    @(posedge clk_sys) lcd_drive_voltage_external <= 1'b1;
    @(negedge clk_sys);
    pw(5'h01);
    hc(10'h15a);
    chk({23'h0, ram_write_strobe, ram_write_data}, 32'h15a);
    hc(10'h024);
    chk({23'h0, cmd_strobe, cmd_byte}, 32'h124);
    hc(10'h200);
    host_bus_model_inst.rd(4'h8, d);
    chk(d, 32'hc2);
    host_bus_model_inst.rd(4'hc, d);
    chk(d, 32'h0);
    $display("test sleep done");
    hc(10'h0e2);
    st(8'h0c);
    pw(5'h01);
    hc(10'h0af);
    hc(10'h200);
    host_bus_model_inst.rd(4'h8, d);
    chk(d, 32'h0c);
    settle;
    st(8'h00);
    @(posedge clk_sys) reset_pin_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    reset_pin_n <= 1'b1;
    st(8'h0c);
    settle;
    st(8'h00);
    $display("test system reset done");
    final_report;
  end
endmodule : tb
`default_nettype wire
